/* hdl/cfg_byte_reg.sv */
// One write-protected configuration byte with a writable-bit mask.
`timescale 1ns/1ps
module cfg_byte_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WR_MASK   = 8'hFF
) (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       nrst_i,
  // Write port
  input  wire logic       wr_en_i,
  input  wire logic [7:0] wr_data_i,
  // Stored value
  output logic      [7:0] value_o
);

  logic [7:0] value_r;
  logic [7:0] value_nxt;

  // Masked bits store zero on each write, so reserved positions read as zero, except RESET_VAL bits before the first write.
  always_comb begin
    value_nxt = value_r;
    if (wr_en_i) begin
      value_nxt = wr_data_i & WR_MASK;
    end
  end

  // Register stage.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      value_r <= RESET_VAL;
    end else begin
      value_r <= value_nxt;
    end
  end

  assign value_o = value_r;

endmodule // cfg_byte_reg

/* hdl/ois_chain_config_regs.sv */
// Stabilisation chain configuration register bank with decoded controls.
`timescale 1ns/1ps
module ois_chain_config_regs (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       nrst_i,
  // Auxiliary serial port register access (read/write)
  input  wire logic       aux_wr_i,
  input  wire logic       aux_rd_i,
  input  wire logic [7:0] aux_addr_i,
  input  wire logic [7:0] aux_wdata_i,
  output logic      [7:0] aux_rdata_o,
  output logic            aux_rvalid_o,
  // Primary host register access (read only)
  input  wire logic       host_wr_i,
  input  wire logic       host_rd_i,
  input  wire logic [7:0] host_addr_i,
  input  wire logic [7:0] host_wdata_i,
  output logic      [7:0] host_rdata_o,
  output logic            host_rvalid_o,
  // Neighbouring register bit and data-enable pin
  input  wire logic       trigger_level_sel_b_i,
  input  wire logic       data_enable_input_i,
  // Decoded controls
  output logic            aux_port_three_wire_o,
  output logic            gyro_chain_active_o,
  output logic            accel_chain_active_o,
  output logic [11:0]     gyro_range_dps_o,
  output logic [1:0]      trigger_mode_o,
  output logic            gyro_data_gate_o,
  output logic            accel_data_gate_o,
  output logic            highpass_enable_o,
  output logic [1:0]      highpass_cutoff_select_o,
  output logic [1:0]      lowpass_bandwidth_select_o,
  output logic            first_lowpass_stage_owned_o,
  output logic            aux_serves_gyro_o,
  output logic            aux_serves_accel_o
);

  // ==========================================================================
  // Storage
  logic [7:0] ctrl_one;
  logic [7:0] filter_ctrl;
  logic       wr_ctrl_one;
  logic       wr_filter;

  // Only the auxiliary port strobe reaches the write enables; host writes
  // are dropped here so the stored value stays unchanged.
  assign wr_ctrl_one = aux_wr_i && (aux_addr_i == stab_cfg_pkg::ADDR_CTRL_ONE);
  assign wr_filter   = aux_wr_i && (aux_addr_i == stab_cfg_pkg::ADDR_FILTER_CTRL);

  cfg_byte_reg #(
    .RESET_VAL (stab_cfg_pkg::CTRL_ONE_RST),
    .WR_MASK   (stab_cfg_pkg::CTRL_ONE_MASK)
  ) u_ctrl_one (
    .clock_i   (clock_i),
    .nrst_i    (nrst_i),
    .wr_en_i   (wr_ctrl_one),
    .wr_data_i (aux_wdata_i),
    .value_o   (ctrl_one)
  );

  cfg_byte_reg #(
    .RESET_VAL (stab_cfg_pkg::FILTER_CTRL_RST),
    .WR_MASK   (stab_cfg_pkg::FILTER_MASK)
  ) u_filter (
    .clock_i   (clock_i),
    .nrst_i    (nrst_i),
    .wr_en_i   (wr_filter),
    .wr_data_i (aux_wdata_i),
    .value_o   (filter_ctrl)
  );

  // ==========================================================================
  // Field extraction
  logic       main_en;
  logic       accel_en;
  logic       low_range;
  logic [1:0] range_sel;
  logic       trig_a;

  assign main_en   = ctrl_one[stab_cfg_pkg::POS_ENABLE];
  assign accel_en  = ctrl_one[stab_cfg_pkg::POS_ACCEL_EN];
  assign low_range = ctrl_one[stab_cfg_pkg::POS_LOW_RANGE];
  assign range_sel = {ctrl_one[stab_cfg_pkg::POS_RANGE_HI], ctrl_one[stab_cfg_pkg::POS_RANGE_LO]};
  assign trig_a    = ctrl_one[stab_cfg_pkg::POS_TRIG_A];

  // ==========================================================================
  // Read paths; both ports see the same map, host data is never stored.
  function automatic logic [7:0] read_map(input logic [7:0] addr, input logic [7:0] c1, input logic [7:0] c2);
    logic [7:0] d;
    d = 8'h00;
    if (addr == stab_cfg_pkg::ADDR_CTRL_ONE) begin
      d = c1;
    end else if (addr == stab_cfg_pkg::ADDR_FILTER_CTRL) begin
      d = c2;
    end
    return d;
  endfunction

  logic [7:0] aux_rdata_r;
  logic [7:0] aux_rdata_nxt;
  logic       aux_rvalid_r;
  logic       aux_rvalid_nxt;
  logic [7:0] host_rdata_r;
  logic [7:0] host_rdata_nxt;
  logic       host_rvalid_r;
  logic       host_rvalid_nxt;
  logic       host_wr_unused;
  logic [7:0] host_wdata_unused;

  // Host write inputs exist for symmetry and are deliberately discarded.
  assign host_wr_unused    = host_wr_i;
  assign host_wdata_unused = host_wdata_i;

  // Next read data: one cycle after the strobe, data loads and holds, valid pulses.
  always_comb begin
    aux_rvalid_nxt  = aux_rd_i;
    host_rvalid_nxt = host_rd_i;
    aux_rdata_nxt   = aux_rdata_r;
    host_rdata_nxt  = host_rdata_r;
    if (aux_rd_i) begin
      aux_rdata_nxt = read_map(aux_addr_i, ctrl_one, filter_ctrl);
    end
    if (host_rd_i) begin
      host_rdata_nxt = read_map(host_addr_i, ctrl_one, filter_ctrl);
    end
  end

  // Read register stage.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aux_rdata_r   <= 8'h00;
      aux_rvalid_r  <= 1'b0;
      host_rdata_r  <= 8'h00;
      host_rvalid_r <= 1'b0;
    end else begin
      aux_rdata_r   <= aux_rdata_nxt;
      aux_rvalid_r  <= aux_rvalid_nxt;
      host_rdata_r  <= host_rdata_nxt;
      host_rvalid_r <= host_rvalid_nxt;
    end
  end

  // ==========================================================================
  // Control decode
  logic [11:0]              range_nxt;
  stab_cfg_pkg::trig_mode_t trig_mode_nxt;
  logic                     gyro_act_nxt;
  logic                     accel_act_nxt;
  logic                     latch_r;
  logic                     latch_nxt;
  logic                     gyro_gate_nxt;

  // Gyro range: override wins over the two-bit field.
  always_comb begin
    range_nxt = stab_cfg_pkg::RANGE_250;
    if (low_range) begin
      range_nxt = stab_cfg_pkg::RANGE_125;
    end else begin
      case (range_sel)
        2'h0:    range_nxt = stab_cfg_pkg::RANGE_250;
        2'h1:    range_nxt = stab_cfg_pkg::RANGE_500;
        2'h2:    range_nxt = stab_cfg_pkg::RANGE_1000;
        2'h3:    range_nxt = stab_cfg_pkg::RANGE_2000;
        default: range_nxt = stab_cfg_pkg::RANGE_250;
      endcase
    end
  end

  // Chain activity; accel needs the main enable too, so accel enable alone
  // never starts it even if the controller forgets the main bit.
  always_comb begin
    gyro_act_nxt  = main_en;
    accel_act_nxt = main_en && accel_en;
  end

  // Data-enable mode from the two trigger bits, first-register bit first.
  always_comb begin
    case ({trig_a, trigger_level_sel_b_i})
      2'b10:   trig_mode_nxt = stab_cfg_pkg::TRIG_LEVEL;
      2'b11:   trig_mode_nxt = stab_cfg_pkg::TRIG_LATCHED;
      default: trig_mode_nxt = stab_cfg_pkg::TRIG_OFF;
    endcase
  end

  // Gyro data gate: trigger follows the pin, latched mode holds once seen.
  // The latch clears when the mode leaves latched or on reset; these are the only releases.
  always_comb begin
    latch_nxt     = 1'b0;
    gyro_gate_nxt = 1'b1;
    case (trig_mode_nxt)
      stab_cfg_pkg::TRIG_LEVEL: begin
        gyro_gate_nxt = data_enable_input_i;
      end
      stab_cfg_pkg::TRIG_LATCHED: begin
        latch_nxt     = latch_r || data_enable_input_i;
        gyro_gate_nxt = latch_nxt;
      end
      default: begin
        gyro_gate_nxt = 1'b1;
      end
    endcase
    gyro_gate_nxt = gyro_gate_nxt && gyro_act_nxt;
  end

  // Output register stage; every decoded control comes from a flip-flop.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      latch_r                     <= 1'b0;
      aux_port_three_wire_o       <= 1'b0;
      gyro_chain_active_o         <= 1'b0;
      accel_chain_active_o        <= 1'b0;
      gyro_range_dps_o            <= stab_cfg_pkg::RANGE_250;
      trigger_mode_o              <= 2'h0;
      gyro_data_gate_o            <= 1'b0;
      accel_data_gate_o           <= 1'b0;
      highpass_enable_o           <= 1'b0;
      highpass_cutoff_select_o    <= 2'h0;
      lowpass_bandwidth_select_o  <= 2'h0;
      first_lowpass_stage_owned_o <= 1'b0;
      aux_serves_gyro_o           <= 1'b0;
      aux_serves_accel_o          <= 1'b0;
    end else begin
      latch_r                     <= latch_nxt;
      aux_port_three_wire_o       <= ctrl_one[stab_cfg_pkg::POS_THREE_WIRE];
      gyro_chain_active_o         <= gyro_act_nxt;
      accel_chain_active_o        <= accel_act_nxt;
      gyro_range_dps_o            <= range_nxt;
      trigger_mode_o              <= trig_mode_nxt;
      gyro_data_gate_o            <= gyro_gate_nxt;
      accel_data_gate_o           <= accel_act_nxt;
      highpass_enable_o           <= filter_ctrl[stab_cfg_pkg::POS_HP_EN];
      highpass_cutoff_select_o    <= {filter_ctrl[stab_cfg_pkg::POS_HP_HI],
                                      filter_ctrl[stab_cfg_pkg::POS_HP_LO]};
      lowpass_bandwidth_select_o  <= {filter_ctrl[stab_cfg_pkg::POS_LP_HI],
                                      filter_ctrl[stab_cfg_pkg::POS_LP_LO]};
      first_lowpass_stage_owned_o <= gyro_act_nxt;
      aux_serves_gyro_o           <= gyro_act_nxt;
      aux_serves_accel_o          <= accel_act_nxt;
    end
  end

  assign aux_rdata_o   = aux_rdata_r;
  assign aux_rvalid_o  = aux_rvalid_r;
  assign host_rdata_o  = host_rdata_r;
  assign host_rvalid_o = host_rvalid_r;

endmodule // ois_chain_config_regs

/* hdl/stab_cfg_pkg.sv */
// Constants for the stabilisation chain configuration register bank.
//
// Contract
// - Chain configuration registers are writable only from the auxiliary serial port.
// - Wire-mode bit 0 selects 4-wire auxiliary port, 1 selects 3-wire.
// - Accel chain enable processes accel data, served at addresses 28h-2Dh.
// - Gyro range field: 00=250, 01=500, 10=1000, 11=2000 dps.
// - Low-range override bit forces 125 dps, else range field decides.
// - Main enable: gyro processing in modes 3 and 4, accel only in 4.
// - Enabled chain serves gyro outputs from 22h, status 1Eh, owns first lowpass.
// - Trigger bits a,b: 10 level trigger, 11 level latched data-enable mode.
// - Data-enable gating affects gyro data only, never accel chain data.
// - Highpass cutoff field: 00=16mHz, 01=65mHz, 10=260mHz, 11=1.04Hz.
// - Highpass enable bit inserts highpass filter; cleared bypasses it.
// - Lowpass field: 00=335.5, 01=232.0, 10=171.1, 11=609.0 Hz.
// - Second trigger bit lives in neighbouring register, default 0, enables latched.
package stab_cfg_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] ADDR_CTRL_ONE    = 8'h70;
  localparam logic [7:0] ADDR_FILTER_CTRL = 8'h71;
  localparam logic [7:0] ADDR_STATUS      = 8'h1E;
  localparam logic [7:0] ADDR_GYRO_FIRST  = 8'h22;
  localparam logic [7:0] ADDR_GYRO_LAST   = 8'h27;
  localparam logic [7:0] ADDR_ACCEL_FIRST = 8'h28;
  localparam logic [7:0] ADDR_ACCEL_LAST  = 8'h2D;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] CTRL_ONE_RST     = 8'h00;
  localparam logic [7:0] FILTER_CTRL_RST  = 8'h00;

  // ==========================================================================
  // Field positions, control register one
  localparam int unsigned POS_ENABLE      = 0;
  localparam int unsigned POS_LOW_RANGE   = 1;
  localparam int unsigned POS_RANGE_LO    = 2;
  localparam int unsigned POS_RANGE_HI    = 3;
  localparam int unsigned POS_ACCEL_EN    = 4;
  localparam int unsigned POS_THREE_WIRE  = 5;
  localparam int unsigned POS_TRIG_A      = 6;
  localparam logic [7:0]  CTRL_ONE_MASK   = 8'h7F;

  // Field positions, filter control register
  localparam int unsigned POS_HP_EN       = 0;
  localparam int unsigned POS_LP_LO       = 1;
  localparam int unsigned POS_LP_HI       = 2;
  localparam int unsigned POS_HP_LO       = 4;
  localparam int unsigned POS_HP_HI       = 5;
  localparam logic [7:0]  FILTER_MASK     = 8'h37;

  // ==========================================================================
  // Decoded gyro range, in dps
  localparam logic [11:0] RANGE_125       = 12'h07D;
  localparam logic [11:0] RANGE_250       = 12'h0FA;
  localparam logic [11:0] RANGE_500       = 12'h1F4;
  localparam logic [11:0] RANGE_1000      = 12'h3E8;
  localparam logic [11:0] RANGE_2000      = 12'h7D0;

  // Data-enable trigger modes.
  typedef enum logic [1:0] {
    TRIG_OFF,
    TRIG_LEVEL,
    TRIG_LATCHED
  } trig_mode_t;

endpackage

/* test/aux_ctrl_model.sv */
// Behavioural stabilisation controller on the auxiliary register port.
`timescale 1ns/1ps
module aux_ctrl_model (
  // Clock and answers
  input  wire logic       clock_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i,
  // Requests
  output logic            wr_o,
  output logic            rd_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o
);
  // Idle request lines start low.
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  // The released data bus shows the inverse of its last value, so stale data cannot pass.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d & ((a == stab_cfg_pkg::ADDR_CTRL_ONE) ? stab_cfg_pkg::CTRL_ONE_MASK
                                                        : stab_cfg_pkg::FILTER_MASK);
    @(posedge clock_i);
    wr_o <= 1'b0;
    wdata_o <= ~wdata_o;
  endtask
  // Read data is taken one cycle after the strobe edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clock_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge clock_i);
    rd_o <= 1'b0;
    #1;
    d = rdata_i;
    v = rvalid_i;
  endtask
endmodule // aux_ctrl_model

/* test/ois_cfg_properties.sv */
// Port-level assertions for the stabilisation chain configuration bank.
`timescale 1ns/1ps
module stab_cfg_checker (
  // Clock, reset and access strobes
  input wire logic        clock_i,
  input wire logic        nrst_i,
  input wire logic        aux_wr_i,
  input wire logic        aux_rd_i,
  input wire logic        host_rd_i,
  input wire logic [7:0]  aux_addr_i,
  input wire logic [7:0]  aux_wdata_i,
  // Answers and decoded controls
  input wire logic        aux_rvalid_o,
  input wire logic        host_rvalid_o,
  input wire logic        aux_port_three_wire_o,
  input wire logic        gyro_chain_active_o,
  input wire logic        accel_chain_active_o,
  input wire logic        accel_data_gate_o,
  input wire logic        aux_serves_gyro_o,
  input wire logic        aux_serves_accel_o,
  input wire logic        first_lowpass_stage_owned_o,
  input wire logic [11:0] gyro_range_dps_o,
  input wire logic [1:0]  highpass_cutoff_select_o
);
  // ==========================================================================
  // Assertions, all in the one clock domain.
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // Two quiet write cycles cover the full two-cycle decode latency.
  sequence s_quiet; !aux_wr_i [*2]; endsequence
  sequence s_ctrl_wr; aux_wr_i && aux_addr_i == stab_cfg_pkg::ADDR_CTRL_ONE; endsequence
  a_accel_needs_main: assert property (accel_chain_active_o |-> gyro_chain_active_o)
    else $error("accel chain active without main enable");
  a_accel_gate_free: assert property (accel_data_gate_o == accel_chain_active_o)
    else $error("accel data gate follows something besides chain enable");
  a_serves_accel: assert property (aux_serves_accel_o == accel_chain_active_o)
    else $error("accel outputs served without active accel chain");
  a_serves_gyro: assert property (aux_serves_gyro_o == gyro_chain_active_o
    && first_lowpass_stage_owned_o == gyro_chain_active_o) else $error("gyro serving mismatch");
  a_host_rd_answer: assert property (host_rd_i |=> host_rvalid_o)
    else $error("host read not answered next cycle");
  a_aux_rd_answer: assert property (aux_rd_i |=> aux_rvalid_o)
    else $error("aux read not answered next cycle");
  a_cfg_holds_quiet: assert property (s_quiet |=> $stable({gyro_range_dps_o,
    highpass_cutoff_select_o, aux_port_three_wire_o})) else $error("config moved without aux write");
  a_wire_follows_write: assert property (s_ctrl_wr |-> ##2
    aux_port_three_wire_o == $past(aux_wdata_i[5], 2)) else $error("wire mode not taken from write");
endmodule // stab_cfg_checker

bind ois_chain_config_regs stab_cfg_checker u_chk (.*);

/* test/ois_chain_config_regs_tb.sv */
// Self-checking bench for the stabilisation chain configuration bank.
`timescale 1ns/1ps
module ois_chain_config_regs_tb;
  // ==========================================================================
  // Signals, named as the design ports so the instance connects by name.
  logic clock_i = 1'b0, nrst_i = 1'b0, host_wr_i = 1'b0, host_rd_i = 1'b0;
  logic trigger_level_sel_b_i = 1'b0, data_enable_input_i = 1'b0;
  logic [7:0] host_addr_i = 8'h00, host_wdata_i = 8'h00, aux_addr_i, aux_wdata_i, aux_rdata_o, host_rdata_o;
  logic aux_wr_i, aux_rd_i, aux_rvalid_o, host_rvalid_o, aux_port_three_wire_o, gyro_chain_active_o;
  logic accel_chain_active_o, gyro_data_gate_o, accel_data_gate_o, highpass_enable_o;
  logic first_lowpass_stage_owned_o, aux_serves_gyro_o, aux_serves_accel_o;
  logic [11:0] gyro_range_dps_o;
  logic [1:0] trigger_mode_o, highpass_cutoff_select_o, lowpass_bandwidth_select_o;
  logic [31:0] seed = 32'h77CB82E2;
  int error_cnt = 0, checked = 0, cycles = 0, m1 = 0, m2 = 0;

  ois_chain_config_regs u_dut (.*);
  aux_ctrl_model u_ctl (.clock_i(clock_i), .rdata_i(aux_rdata_o), .rvalid_i(aux_rvalid_o),
    .wr_o(aux_wr_i), .rd_o(aux_rd_i), .addr_o(aux_addr_i), .wdata_o(aux_wdata_i));

  // 250 MHz clock; the cycle ceiling is far above the few hundred cycles needed.
  always #2 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cycles++;
    if (cycles > 5000) begin
      error_cnt++;
      results;
    end
  end

  // ==========================================================================
  // Helpers.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic settle;
    repeat (3) @(posedge clock_i);
    #1;
  endtask
  // Host writes must leave every register untouched.
  task automatic hwrite(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    host_wr_i <= 1'b1;
    host_addr_i <= a;
    host_wdata_i <= d;
    @(posedge clock_i);
    host_wr_i <= 1'b0;
    host_wdata_i <= ~d;
  endtask
  task automatic rdboth(input logic [7:0] a, input int exp);
    logic [7:0] d;
    logic v;
    u_ctl.rd(a, d, v);
    chk({v, d}, 12'h100 | exp[7:0]);
    @(posedge clock_i);
    host_rd_i <= 1'b1;
    host_addr_i <= a;
    @(posedge clock_i);
    host_rd_i <= 1'b0;
    #1;
    chk({host_rvalid_o, host_rdata_o}, 12'h100 | exp[7:0]);
  endtask
  // Every decoded control against the integer model of both registers.
  // The gate expectation assumes latched mode is not selected, true wherever this task is called.
  task automatic cmp_cfg;
    int en;
    int ac;
    int tm;
    en = m1 & 1;
    ac = en & (m1 >> 4);
    tm = stab_cfg_pkg::TRIG_OFF;
    if ((m1 >> 6) & 1) begin
      tm = trigger_level_sel_b_i ? stab_cfg_pkg::TRIG_LATCHED : stab_cfg_pkg::TRIG_LEVEL;
    end
    chk(gyro_chain_active_o, en);
    chk({accel_chain_active_o, aux_serves_accel_o, accel_data_gate_o}, ac * 7);
    chk({aux_serves_gyro_o, first_lowpass_stage_owned_o}, en * 3);
    chk(aux_port_three_wire_o, (m1 >> 5) & 1);
    chk(gyro_range_dps_o, (m1 & 2) ? 125 : 250 << ((m1 >> 2) & 3));
    chk(highpass_enable_o, m2 & 1);
    chk(lowpass_bandwidth_select_o, (m2 >> 1) & 3);
    chk(highpass_cutoff_select_o, (m2 >> 4) & 3);
    chk(trigger_mode_o, tm);
    chk(gyro_data_gate_o, en & ((tm == stab_cfg_pkg::TRIG_LEVEL) ? data_enable_input_i : 1));
    rdboth(8'h70, m1);
    rdboth(8'h71, m2);
  endtask
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence.
  initial begin
    repeat (2) @(posedge clock_i);
    nrst_i <= 1'b1;
    #1;
    cmp_cfg;
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      m1 = (seed & 32'h70) | i;
      m2 = ((i & 3) << 4) | (((i >> 2) & 3) << 1) | seed[7];
      u_ctl.wr(8'h70, m1[7:0]);
      u_ctl.wr(8'h71, m2[7:0]);
      hwrite({7'h38, i[0]}, seed[15:8]);
      settle;
      cmp_cfg;
    end
    // Pin and trigger bit changes are launched on a rising edge.
    m1 = 32'h51;
    u_ctl.wr(8'h70, 8'h51);
    data_enable_input_i <= 1'b1;
    settle;
    chk(trigger_mode_o, stab_cfg_pkg::TRIG_LEVEL);
    chk({gyro_data_gate_o, accel_data_gate_o}, 3);
    @(posedge clock_i);
    data_enable_input_i <= 1'b0;
    settle;
    chk({gyro_data_gate_o, accel_data_gate_o}, 1);
    @(posedge clock_i);
    trigger_level_sel_b_i <= 1'b1;
    data_enable_input_i <= 1'b1;
    settle;
    @(posedge clock_i);
    data_enable_input_i <= 1'b0;
    settle;
    chk({trigger_mode_o, gyro_data_gate_o}, {stab_cfg_pkg::TRIG_LATCHED, 1'b1});
    m1 = 32'h11;
    u_ctl.wr(8'h70, 8'h11);
    settle;
    chk(trigger_mode_o, stab_cfg_pkg::TRIG_OFF);
    cmp_cfg;
    rdboth(stab_cfg_pkg::ADDR_STATUS, 0);
    @(posedge clock_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    nrst_i <= 1'b1;
    m1 = 0;
    m2 = 0;
    #1;
    cmp_cfg;
    results;
  end
endmodule // ois_chain_config_regs_tb
